// ===== haptic_status_id_regs.v
// status, identification and upper register bank behind an axi4-lite slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "haptic_status_consts.vh"

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - diag mode: open/short fault sets diag fail
// - calibration mode: failure sets diag fail
// - impedance mode: result to impedance register only
// - status event bits sticky, cleared by read
// - bad memory format sets format error
// - sequencer/diag/cal completion sets done bit
// - identification read-only: part code, revision
// - five-bit mask gates status onto trigger pin
// - droop, overtemp, overcurrent also sticky, read-clear
module haptic_status_id_regs #(
  parameter [3:0] PART_CODE = 4'h5,  // arbitrary value
  parameter [3:0] REV_CODE = 4'h7,   // arbitrary value
  parameter MEM_AW = 8
) (
  // clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // axi4-lite write address and data
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  // axi4-lite write response
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // events from the drive core, one-cycle pulses
  input wire ACT_FAULT,
  input wire CAL_FAIL,
  input wire IMPED_VALID,
  input wire [7:0] IMPED_VALUE,
  input wire MEM_FORMAT_BAD,
  input wire SEQ_DONE,
  input wire DIAG_DONE,
  input wire CAL_DONE,
  input wire DROOP_EVENT,
  input wire OVERTEMP_EVENT,
  input wire OVERCUR_EVENT,
  // trigger/interrupt pin, active low open drain
  output reg TRIG_IRQ_PIN_O,
  output reg TRIG_IRQ_PIN_OE
);

  //////////////////////////////////////////////////////////////////////////
  // register state: drive timing and clamp settings
  reg [7:0] clamp1_q;
  reg [7:0] clamp2_q;
  reg [7:0] drv_time_q;
  reg [7:0] blank_q;
  reg [7:0] clamp_time_q;
  reg [7:0] cal_time_q;
  // open-loop fallback and current scaling
  reg [7:0] ol_shape_q;
  reg [7:0] ol_per_hi_q;
  reg [7:0] ol_per_lo_q;
  reg [7:0] cur_k_q;
  // memory pointer, run mode and measured impedance
  reg [7:0] ptr_hi_q;
  reg [7:0] ptr_lo_q;
  reg [7:0] mode_q;
  reg [7:0] imped_q;
  // interrupt mask; reserved status bits are plain storage, kept apart so
  // that the clear-on-read path never reaches them
  reg [4:0] irq_mask_q;
  reg [1:0] status_rsv_q;
  reg [7:0] status_q;
  reg [7:0] status_d;
  // waveform bytes; not reset, so software writes before it reads back
  reg [7:0] mem [0:(1<<MEM_AW)-1];

  // axi holding state: the taken index, data and strobes wait here until
  // both halves of a write have arrived
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire [1:0] run_mode = mode_q[1:0];
  wire [15:0] mem_ptr = {ptr_hi_q, ptr_lo_q};
  wire ptr_in_range = (mem_ptr >> MEM_AW) == 16'h0000;
  wire [MEM_AW-1:0] mem_idx = mem_ptr[MEM_AW-1:0];

  // word address to register index
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // true when an index selects a mapped register
  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_IDENT, `IDX_STATUS, `IDX_IRQ_MASK, `IDX_IMPEDANCE,
        `IDX_CLAMP1, `IDX_CLAMP2, `IDX_DRV_TIME, `IDX_BLANK,
        `IDX_CLAMP_TIME, `IDX_CAL_TIME, `IDX_OL_SHAPE, `IDX_OL_PER_HI,
        `IDX_OL_PER_LO, `IDX_CUR_K, `IDX_MODE, `IDX_PTR_HI,
        `IDX_PTR_LO, `IDX_MEM_DATA: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // an event counts only while its owning run mode is selected; used for
  // the fault, calibration and impedance inputs
  function mode_event;
    input [1:0] mode;
    input [1:0] want;
    input ev;
    begin
      mode_event = (mode == want) && ev;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order; each ready
  // drops once taken and rises only after the response is accepted, so
  // one write is in flight at a time
  wire do_write = aw_held_q && w_held_q && !S_AXI_BVALID;
  wire wr_lane = wstrb_q[0];
  wire [7:0] wbyte = wdata_q[7:0];

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= reg_index(S_AXI_AWADDR);
        S_AXI_AWREADY <= 1'b0;
      end

      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end

      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(aw_idx_q) ? `RESP_OKAY : `RESP_SLVERR;
      end

      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // writable registers; only byte lane 0 carries data
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      clamp1_q <= `RST_CLAMP1;
      clamp2_q <= `RST_CLAMP2;
      drv_time_q <= `RST_DRV_TIME;
      blank_q <= `RST_BLANK;
      clamp_time_q <= `RST_CLAMP_TIME;
      cal_time_q <= `RST_CAL_TIME;
      ol_shape_q <= `RST_OL_SHAPE;
      ol_per_hi_q <= `RST_OL_PER_HI;
      ol_per_lo_q <= `RST_OL_PER_LO;
      cur_k_q <= `RST_CUR_K;
      ptr_hi_q <= `RST_BYTE;
      ptr_lo_q <= `RST_BYTE;
      mode_q <= `RST_BYTE;
      irq_mask_q <= `RST_IRQ_MASK;
      status_rsv_q <= 2'b00;
    end else if (do_write && wr_lane) begin
      case (aw_idx_q)
        `IDX_CLAMP1: clamp1_q <= wbyte;
        `IDX_CLAMP2: clamp2_q <= wbyte;
        `IDX_DRV_TIME: drv_time_q <= wbyte;
        `IDX_BLANK: blank_q <= wbyte;
        `IDX_CLAMP_TIME: clamp_time_q <= wbyte;
        `IDX_CAL_TIME: cal_time_q <= wbyte;
        `IDX_OL_SHAPE: ol_shape_q <= wbyte;
        `IDX_OL_PER_HI: ol_per_hi_q <= wbyte;
        `IDX_OL_PER_LO: ol_per_lo_q <= wbyte;
        `IDX_CUR_K: cur_k_q <= wbyte;
        `IDX_MODE: mode_q <= wbyte;
        `IDX_PTR_HI: ptr_hi_q <= wbyte;
        `IDX_PTR_LO: ptr_lo_q <= wbyte;
        `IDX_IRQ_MASK: irq_mask_q <= wbyte[4:0];
        `IDX_STATUS: status_rsv_q <= wbyte[6:5];
        // read-only indices and unmapped ones fall here and change nothing
        default: ;
      endcase
    end
  end

  // memory data port writes the byte at the pointer; pointers past the
  // array are dropped silently
  always @(posedge REF_CLK) begin
    if (do_write && wr_lane && aw_idx_q == `IDX_MEM_DATA && ptr_in_range)
      mem[mem_idx] <= wbyte;
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel; ready stays low until the data is accepted. a status
  // read clears the flags on the taking edge while the data captured there
  // still holds them
  wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [7:0] rd_idx = reg_index(S_AXI_ARADDR);
  wire status_read = rd_take && rd_idx == `IDX_STATUS;
  reg [7:0] rbyte;

  always @* begin
    rbyte = 8'h00;
    case (rd_idx)
      `IDX_IDENT: rbyte = {PART_CODE, REV_CODE};
      `IDX_STATUS: rbyte = {status_q[7], status_rsv_q, status_q[4:0]};
      `IDX_IRQ_MASK: rbyte = {3'b000, irq_mask_q};
      `IDX_IMPEDANCE: rbyte = imped_q;
      `IDX_CLAMP1: rbyte = clamp1_q;
      `IDX_CLAMP2: rbyte = clamp2_q;
      `IDX_DRV_TIME: rbyte = drv_time_q;
      `IDX_BLANK: rbyte = blank_q;
      `IDX_CLAMP_TIME: rbyte = clamp_time_q;
      `IDX_CAL_TIME: rbyte = cal_time_q;
      `IDX_OL_SHAPE: rbyte = ol_shape_q;
      `IDX_OL_PER_HI: rbyte = ol_per_hi_q;
      `IDX_OL_PER_LO: rbyte = ol_per_lo_q;
      `IDX_CUR_K: rbyte = cur_k_q;
      `IDX_MODE: rbyte = mode_q;
      `IDX_PTR_HI: rbyte = ptr_hi_q;
      `IDX_PTR_LO: rbyte = ptr_lo_q;
      `IDX_MEM_DATA:
        rbyte = ptr_in_range ? mem[mem_idx] : 8'h00;
      // unmapped indices read as zero with an error response
      default: rbyte = 8'h00;
    endcase
  end

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else begin
      if (rd_take) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h00_0000, rbyte};
        S_AXI_RRESP <= mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end

      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky status; an event in the clearing cycle survives the read
  always @* begin
    status_d = status_read ? 8'h00 : status_q;

    // a fault counts only in the mode that owns it; impedance mode never
    // reaches bit 7
    if (mode_event(run_mode, `MODE_DIAG, ACT_FAULT) ||
        mode_event(run_mode, `MODE_CAL, CAL_FAIL))
      status_d[`ST_DIAG_FAIL] = 1'b1;
    if (MEM_FORMAT_BAD)
      status_d[`ST_FMT_ERR] = 1'b1;
    if (SEQ_DONE || DIAG_DONE || CAL_DONE)
      status_d[`ST_DONE] = 1'b1;

    // supply and protection events
    if (DROOP_EVENT)
      status_d[`ST_DROOP] = 1'b1;
    if (OVERTEMP_EVENT)
      status_d[`ST_OVERTEMP] = 1'b1;
    if (OVERCUR_EVENT)
      status_d[`ST_OVERCUR] = 1'b1;
    // reserved bits live in their own register
    status_d[6:5] = 2'b00;
  end

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      status_q <= 8'h00;
      imped_q <= 8'h00;
    end else begin
      status_q <= status_d;
      if (mode_event(run_mode, `MODE_IMPED, IMPED_VALID))
        imped_q <= IMPED_VALUE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trigger pin: pulled low while any unmasked flag in status bits 4:0 stands and the pin is
  // in interrupt mode; otherwise released. uses the registered flags, so
  // the pin trails the status register by one cycle
  wire [4:0] raw_irq = status_q[4:0];
  wire irq_any = |(raw_irq & ~irq_mask_q);

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TRIG_IRQ_PIN_O <= 1'b0;
      TRIG_IRQ_PIN_OE <= 1'b0;
    end else begin
      TRIG_IRQ_PIN_O <= 1'b0;
      TRIG_IRQ_PIN_OE <= (mode_q[2] == `MODE_TRIG_IRQ) && irq_any;
    end
  end

endmodule // haptic_status_id_regs

// ===== haptic_status_consts.vh
// register offsets, field positions and reset values of the status/id bank
`ifndef HAPTIC_STATUS_CONSTS_VH
`define HAPTIC_STATUS_CONSTS_VH

// register indices as printed; byte address is four times the index
`define IDX_IDENT      8'h00
`define IDX_STATUS     8'h01
`define IDX_IRQ_MASK   8'h02
`define IDX_IMPEDANCE  8'h03
`define IDX_CLAMP1     8'h25
`define IDX_CLAMP2     8'h26
`define IDX_DRV_TIME   8'h27
`define IDX_BLANK      8'h28
`define IDX_CLAMP_TIME 8'h29
`define IDX_CAL_TIME   8'h2a
`define IDX_OL_SHAPE   8'h2c
`define IDX_OL_PER_HI  8'h2e
`define IDX_OL_PER_LO  8'h2f
`define IDX_CUR_K      8'h30
`define IDX_MODE       8'h31
`define IDX_PTR_HI     8'hfd
`define IDX_PTR_LO     8'hfe
`define IDX_MEM_DATA   8'hff

// reset values
`define RST_CLAMP1     8'h80
`define RST_CLAMP2     8'h00
`define RST_DRV_TIME   8'h10
`define RST_BLANK      8'h11
`define RST_CLAMP_TIME 8'h0c
`define RST_CAL_TIME   8'h02
`define RST_OL_SHAPE   8'h00
`define RST_OL_PER_HI  8'h00
`define RST_OL_PER_LO  8'hc6
`define RST_CUR_K      8'h00
`define RST_IRQ_MASK   5'h18
`define RST_BYTE       8'h00

// status bit positions
`define ST_DIAG_FAIL   7
`define ST_FMT_ERR     4
`define ST_DONE        3
`define ST_DROOP       2
`define ST_OVERTEMP    1
`define ST_OVERCUR     0

// run modes held in the mode register
`define MODE_DIAG      2'b01
`define MODE_CAL       2'b10
`define MODE_IMPED     2'b11
`define MODE_TRIG_IRQ  1'b1

// axi responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// ===== haptic_status_monitor.sv
// assertion checker on the ports of the status/id bank
`timescale 1ns/1ps
module haptic_status_monitor #(
  parameter [3:0] PART_CODE = 4'h5,
  parameter [3:0] REV_CODE = 4'h7
) (
  // clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // bus
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire S_AXI_RVALID,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  // events and pin
  input wire MEM_FORMAT_BAD,
  input wire SEQ_DONE,
  input wire DROOP_EVENT,
  input wire TRIG_IRQ_PIN_O
);
  wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  // two status reads can fall just two cycles apart, so a second one inside the window sees the flags cleared
  wire st_rd = rd_take && S_AXI_ARADDR[9:2] == 8'h01;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
//////////////////////////////////////////////////////////////////////////////
  id_read_a: assert property (
    rd_take && S_AXI_ARADDR[9:2] == 8'h00 |=>
    S_AXI_RDATA[7:0] == {PART_CODE, REV_CODE}) else $error("bad id");
  fmt_sticky_a: assert property (
    MEM_FORMAT_BAD ##[1:3] st_rd |=> S_AXI_RDATA[4]) else $error("fmt lost");
  done_sticky_a: assert property (
    SEQ_DONE ##[1:3] st_rd |=> S_AXI_RDATA[3]) else $error("done lost");
  droop_sticky_a: assert property (
    DROOP_EVENT ##[1:3] st_rd |=> S_AXI_RDATA[2]) else $error("droop lost");
  pin_open_drain_a: assert property (
    !TRIG_IRQ_PIN_O) else $error("pin driven high");
  write_busy_a: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("busy");
  write_answer_a: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##2 S_AXI_BVALID) else $error("no write response");
  read_answer_a: assert property (
    rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("no read data");
endmodule // haptic_status_monitor

// ===== core_model.sv
// drive core stand-in: fires event pulses into the status bank
`timescale 1ns/1ps
module core_model (
  // clock
  input wire clk,
  // events and impedance result
  output reg [9:0] ev,
  output reg [7:0] imp
);
  initial begin
    ev = 10'h000;
    imp = 8'h00;
  end
  // one-cycle pulse; result bus shows inverse data once released
  task pulse(input [9:0] m, input [7:0] v);
    begin
      @(posedge clk);
      ev <= m;
      imp <= v;
      @(posedge clk);
      ev <= 10'h000;
      imp <= ~v;
    end
  endtask
endmodule // core_model

// ===== test_haptic_status_id_regs.sv
// bench driving the status/id bank over axi4-lite
`timescale 1ns/1ps
module test_haptic_status_id_regs;
  // part and revision codes: arbitrary values
  localparam [3:0] PC = 4'h3;
  localparam [3:0] RC = 4'h9;
  reg REF_CLK, RSTN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  reg S_AXI_ARVALID, S_AXI_RREADY;
  reg [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR;
  reg [3:0] S_AXI_WSTRB;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire S_AXI_RVALID, TRIG_IRQ_PIN_O, TRIG_IRQ_PIN_OE;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [9:0] ev;
  wire [7:0] IMPED_VALUE;
  reg [79:0] ix = 80'h2526_2728_292a_2c2e_2f30;
  reg [79:0] rv = 80'h8000_1011_0c02_0000_c600;
  reg [79:0] ex = 80'h0102_0408_0808_1000_0000;
  reg [9:0] pe = 10'h380;
  integer num_errors = 0;
  integer n_compared = 0;
  integer k;
  haptic_status_id_regs #(.PART_CODE(PC), .REV_CODE(RC)) dut (
    .REF_CLK(REF_CLK), .RSTN(RSTN),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .ACT_FAULT(ev[0]), .CAL_FAIL(ev[1]), .IMPED_VALID(ev[2]),
    .MEM_FORMAT_BAD(ev[3]), .SEQ_DONE(ev[4]), .DIAG_DONE(ev[5]),
    .CAL_DONE(ev[6]), .DROOP_EVENT(ev[7]), .OVERTEMP_EVENT(ev[8]),
    .OVERCUR_EVENT(ev[9]), .IMPED_VALUE(IMPED_VALUE),
    .TRIG_IRQ_PIN_O(TRIG_IRQ_PIN_O), .TRIG_IRQ_PIN_OE(TRIG_IRQ_PIN_OE)
  );
  core_model core (.clk(REF_CLK), .ev(ev), .imp(IMPED_VALUE));
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
//////////////////////////////////////////////////////////////////////////////
  task summarize;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task tmo;
    begin
      num_errors = num_errors + 1;
      summarize;
    end
  endtask
  task wr(input [7:0] i, input [7:0] d, input [1:0] r);
    integer n;
    begin
      @(posedge REF_CLK);
      S_AXI_AWADDR <= {22'h0, i, 2'h0};
      S_AXI_WDATA <= {24'h0, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge REF_CLK);
        if (S_AXI_AWREADY)
          S_AXI_AWVALID <= 1'b0;
        if (S_AXI_WREADY)
          S_AXI_WVALID <= 1'b0;
        if (S_AXI_BVALID) begin
          S_AXI_BREADY <= 1'b0;
          chk(S_AXI_BRESP, r);
          n = 99;
        end
      end
      if (n == 40)
        tmo;
    end
  endtask
  task rd(input [7:0] i, input [7:0] e, input [1:0] r);
    integer n;
    begin
      @(posedge REF_CLK);
      S_AXI_ARADDR <= {22'h0, i, 2'h0};
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge REF_CLK);
        if (S_AXI_ARREADY)
          S_AXI_ARVALID <= 1'b0;
        if (S_AXI_RVALID) begin
          S_AXI_RREADY <= 1'b0;
          chk(S_AXI_RDATA, {24'h0, e});
          chk(S_AXI_RRESP, r);
          n = 99;
        end
      end
      if (n == 40)
        tmo;
    end
  endtask
  // pin follows status one edge later
  task pin(input e);
    begin
      @(posedge REF_CLK);
      #1 chk(TRIG_IRQ_PIN_OE, e);
    end
  endtask
//////////////////////////////////////////////////////////////////////////////
  initial begin
    RSTN = 1'b0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    S_AXI_AWADDR = 32'h0;
    S_AXI_WDATA = 32'h0;
    S_AXI_ARADDR = 32'h0;
    S_AXI_WSTRB = 4'hf;
    repeat (12) @(posedge REF_CLK);
    RSTN <= 1'b1;
    wr(8'h00, 8'hff, 2'h0);
    rd(8'h00, {PC, RC}, 2'h0);
    rd(8'h02, 8'h18, 2'h0);
    wr(8'h01, 8'hff, 2'h0);
    rd(8'h01, 8'h60, 2'h0);
    rd(8'h01, 8'h60, 2'h0);
    wr(8'h01, 8'h00, 2'h0);
    for (k = 0; k < 10; k = k + 1) begin
      rd(ix[8*k +: 8], rv[8*k +: 8], 2'h0);
      wr(ix[8*k +: 8], ~ix[8*k +: 8], 2'h0);
      rd(ix[8*k +: 8], ~ix[8*k +: 8], 2'h0);
    end
    S_AXI_WSTRB <= 4'h0;
    wr(8'h30, 8'h77, 2'h0);
    S_AXI_WSTRB <= 4'hf;
    rd(8'h30, 8'hcf, 2'h0);
    rd(8'h40, 8'h00, 2'h2);
    wr(8'h40, 8'h11, 2'h2);
    wr(8'h31, 8'h01, 2'h0);
    core.pulse(10'h001, 8'h00);
    rd(8'h01, 8'h80, 2'h0);
    rd(8'h01, 8'h00, 2'h0);
    wr(8'h31, 8'h02, 2'h0);
    core.pulse(10'h002, 8'h00);
    rd(8'h01, 8'h80, 2'h0);
    wr(8'h31, 8'h03, 2'h0);
    core.pulse(10'h007, 8'h3c);
    rd(8'h01, 8'h00, 2'h0);
    rd(8'h03, 8'h3c, 2'h0);
    wr(8'h31, 8'h04, 2'h0);
    for (k = 3; k < 10; k = k + 1) begin
      core.pulse(10'h001 << k, 8'h00);
      pin(pe[k]);
      rd(8'h01, ex[8*k +: 8], 2'h0);
      rd(8'h01, 8'h00, 2'h0);
    end
    wr(8'h02, 8'h00, 2'h0);
    core.pulse(10'h010, 8'h00);
    pin(1'b1);
    rd(8'h01, 8'h08, 2'h0);
    wr(8'h31, 8'h00, 2'h0);
    core.pulse(10'h080, 8'h00);
    pin(1'b0);
    rd(8'h01, 8'h04, 2'h0);
    wr(8'hfd, 8'h00, 2'h0);
    wr(8'hfe, 8'h12, 2'h0);
    wr(8'hff, 8'h5a, 2'h0);
    wr(8'hfe, 8'h13, 2'h0);
    wr(8'hff, 8'ha5, 2'h0);
    rd(8'hff, 8'ha5, 2'h0);
    wr(8'hfe, 8'h12, 2'h0);
    rd(8'hff, 8'h5a, 2'h0);
    wr(8'hfd, 8'h01, 2'h0);
    wr(8'hff, 8'h33, 2'h0);
    rd(8'hff, 8'h00, 2'h0);
    wr(8'hfd, 8'h00, 2'h0);
    rd(8'hff, 8'h5a, 2'h0);
    summarize;
  end
endmodule // test_haptic_status_id_regs

bind haptic_status_id_regs haptic_status_monitor #(
  .PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) mon (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .MEM_FORMAT_BAD(MEM_FORMAT_BAD),
  .SEQ_DONE(SEQ_DONE), .DROOP_EVENT(DROOP_EVENT),
  .TRIG_IRQ_PIN_O(TRIG_IRQ_PIN_O));
